// >>> dv/lces_top_tb_top.sv
// Self-checking testbench of the coherence event selector over APB
`timescale 1ns/1ns
`include "lces_cfg.svh"
module lces_top_tb_top;
    import lces_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic llc_read_miss = 1'b0;
    logic llc_write_miss = 1'b0;
    logic llc_snoop_miss = 1'b0;
    logic llc_alloc_valid = 1'b0;
    lces_alloc_st_t llc_alloc_state = 4'h0;
    logic llc_alloc_fwd_rio = 1'b0;
    logic llc_victim_valid = 1'b0;
    lces_victim_st_t llc_victim_state = 5'h00;
    logic llc_victim_home_remote = 1'b0;
    logic remote_snoop_valid = 1'b0;
    logic remote_snoop_to_invalid = 1'b0;
    lces_qual_t remote_snoop_prev_state = 4'h0;
    logic wb_home_req;
    logic wb_home_remote;
    int err_total = 0;
    int tests_run = 0;

    always #20 pclk = ~pclk;

    lces_top #(.CNT_W(48)) lces_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .llc_read_miss(llc_read_miss), .llc_write_miss(llc_write_miss),
        .llc_snoop_miss(llc_snoop_miss), .llc_alloc_valid(llc_alloc_valid), .llc_alloc_state(llc_alloc_state),
        .llc_alloc_fwd_rio(llc_alloc_fwd_rio), .llc_victim_valid(llc_victim_valid),
        .llc_victim_state(llc_victim_state), .llc_victim_home_remote(llc_victim_home_remote),
        .remote_snoop_valid(remote_snoop_valid), .remote_snoop_to_invalid(remote_snoop_to_invalid),
        .remote_snoop_prev_state(remote_snoop_prev_state), .wb_home_req(wb_home_req),
        .wb_home_remote(wb_home_remote));

    task results();
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t ns: seen %08h expected %08h", $time, seen, exp);
        end
    endtask

    // Request held from setup until pready is sampled high
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (i == 16) begin
            err_total++;
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
    endtask

    task rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask

    // One occurrence cycle; qualifiers are inverted afterwards so stale values cannot count
    task fire(input logic [2:0] m, input lces_alloc_st_t ast, input logic fw, input lces_victim_st_t vst,
        input logic hr, input logic [1:0] sn, input lces_qual_t sp);
        logic exp_wb;
        exp_wb = vst[0];
        @(posedge pclk);
        llc_read_miss <= m[0];
        llc_write_miss <= m[1];
        llc_snoop_miss <= m[2];
        llc_alloc_valid <= |ast;
        llc_alloc_state <= ast;
        llc_alloc_fwd_rio <= fw;
        llc_victim_valid <= |vst;
        llc_victim_state <= vst;
        llc_victim_home_remote <= hr;
        remote_snoop_valid <= sn[1];
        remote_snoop_to_invalid <= sn[0];
        remote_snoop_prev_state <= sp;
        @(posedge pclk);
        {llc_read_miss, llc_write_miss, llc_snoop_miss} <= 3'b000;
        llc_alloc_valid <= 1'b0;
        llc_alloc_state <= ~ast;
        llc_alloc_fwd_rio <= ~fw;
        llc_victim_valid <= 1'b0;
        llc_victim_state <= ~vst;
        llc_victim_home_remote <= ~hr;
        remote_snoop_valid <= 1'b0;
        remote_snoop_to_invalid <= ~sn[0];
        remote_snoop_prev_state <= ~sp;
        #1;
        check({31'h0, wb_home_req}, {31'h0, exp_wb});
        if (exp_wb) begin
            check({31'h0, wb_home_remote}, {31'h0, hr});
            @(posedge pclk);
            #1;
            check({31'h0, wb_home_req}, 32'h0000_0000);
            check({31'h0, wb_home_remote}, {31'h0, hr});
        end
    endtask

    // Same mix of occurrences for every selection
    task fire_all();
        fire(3'b111, 4'h0, 1'b0, 5'h00, 1'b0, 2'b00, 4'h0);
        fire(3'b001, 4'h0, 1'b0, 5'h00, 1'b0, 2'b00, 4'h0);
        fire(3'b000, 4'h1, 1'b0, 5'h00, 1'b0, 2'b00, 4'h0);
        for (int i = 0; i < 4; i++) begin
            fire(3'b000, lces_alloc_st_t'(4'h1 << i), 1'b1, 5'h00, 1'b0, 2'b00, 4'h0);
        end
        for (int i = 0; i < 5; i++) begin
            fire(3'b000, 4'h0, 1'b0, lces_victim_st_t'(5'h01 << i), 1'b1, 2'b00, 4'h0);
        end
        fire(3'b000, 4'h0, 1'b0, 5'h01, 1'b0, 2'b00, 4'h0);
        fire(3'b000, 4'h0, 1'b0, 5'h00, 1'b0, 2'b10, 4'h2);
        fire(3'b000, 4'h0, 1'b0, 5'h00, 1'b0, 2'b10, 4'h8);
        fire(3'b000, 4'h0, 1'b0, 5'h00, 1'b0, 2'b11, 4'h2);
        fire(3'b000, 4'h0, 1'b0, 5'h00, 1'b0, 2'b11, 4'h1);
    endtask

    task run_case(input logic [7:0] evt, input logic [7:0] um, input lces_qual_t q, input logic en,
        input logic [31:0] exp);
        wr(`LCES_OFF_QUAL, {28'h0, q}, 4'hF);
        wr(`LCES_OFF_SEL, {15'h0, en, um, evt}, 4'hF);
        wr(`LCES_OFF_CNT_LO, 32'h0000_0000, 4'hF);
        wr(`LCES_OFF_CNT_HI, 32'h0000_0000, 4'hF);
        fire_all();
        rd_chk(`LCES_OFF_CNT_LO, exp, 1'b0);
        rd_chk(`LCES_OFF_CNT_HI, 32'h0000_0000, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`LCES_OFF_SEL, 32'h0000_0000, 1'b0);
        rd_chk(`LCES_OFF_CNT_LO, 32'h0000_0000, 1'b0);
        rd_chk(`LCES_OFF_QUAL, 32'h0000_0000, 1'b0);
        rd_chk(16'h0010, 32'h0000_0000, 1'b1);
        wr(`LCES_OFF_SEL, 32'hFFFF_FFFF, 4'hF);
        rd_chk(`LCES_OFF_SEL, 32'h0001_FFFF, 1'b0);
        wr(`LCES_OFF_SEL, 32'h0000_0000, 4'h1);
        rd_chk(`LCES_OFF_SEL, 32'h0001_FF00, 1'b0);
        wr(`LCES_OFF_QUAL, 32'h0000_00FF, 4'hF);
        rd_chk(`LCES_OFF_QUAL, 32'h0000_000F, 1'b0);
        run_case(8'h09, 8'h01, 4'h0, 1'b1, 32'h0000_0002);
        run_case(8'h09, 8'h02, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h09, 8'h04, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h09, 8'h03, 4'h0, 1'b1, 32'h0000_0003);
        run_case(8'h09, 8'h01, 4'h0, 1'b0, 32'h0000_0000);
        run_case(8'h0A, 8'h01, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0A, 8'h02, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0A, 8'h04, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0A, 8'h08, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0A, 8'h0F, 4'h0, 1'b1, 32'h0000_0004);
        run_case(8'h0B, 8'h01, 4'h0, 1'b1, 32'h0000_0002);
        run_case(8'h0B, 8'h02, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0B, 8'h04, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0B, 8'h08, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0B, 8'h10, 4'h0, 1'b1, 32'h0000_0001);
        run_case(8'h0B, 8'h1F, 4'h0, 1'b1, 32'h0000_0006);
        run_case(8'h0C, 8'h01, 4'h0, 1'b1, 32'h0000_0002);
        run_case(8'h0C, 8'h02, 4'h0, 1'b1, 32'h0000_0002);
        run_case(8'h0C, 8'h04, 4'h2, 1'b1, 32'h0000_0001);
        run_case(8'h0C, 8'h04, 4'h8, 1'b1, 32'h0000_0001);
        run_case(8'h0C, 8'h04, 4'h1, 1'b1, 32'h0000_0000);
        run_case(8'h0C, 8'h04, 4'h4, 1'b1, 32'h0000_0000);
        run_case(8'h0C, 8'h08, 4'h2, 1'b1, 32'h0000_0001);
        run_case(8'h0C, 8'h08, 4'h1, 1'b1, 32'h0000_0001);
        run_case(8'h0C, 8'h08, 4'h8, 1'b1, 32'h0000_0000);
        run_case(8'h08, 8'hFF, 4'hF, 1'b1, 32'h0000_0000);
        // Carry from low into high word of the counter
        wr(`LCES_OFF_SEL, 32'h0001_0109, 4'hF);
        wr(`LCES_OFF_CNT_LO, 32'hFFFF_FFFF, 4'hF);
        wr(`LCES_OFF_CNT_HI, 32'h0000_0000, 4'hF);
        fire(3'b001, 4'h0, 1'b0, 5'h00, 1'b0, 2'b00, 4'h0);
        rd_chk(`LCES_OFF_CNT_LO, 32'h0000_0000, 1'b0);
        rd_chk(`LCES_OFF_CNT_HI, 32'h0000_0001, 1'b0);
        wr(`LCES_OFF_SEL, 32'h0000_0000, 4'hF);
        wr(`LCES_OFF_CNT_HI, 32'hFFFF_FFFF, 4'hF);
        rd_chk(`LCES_OFF_CNT_HI, 32'h0000_FFFF, 1'b0);
        results();
    end
endmodule

// >>> rtl/lces_cfg.svh
// Offsets, field positions, reset values and event codes of the event selector
`ifndef LCES_CFG_SVH
`define LCES_CFG_SVH

`define LCES_OFF_SEL 16'h0000
`define LCES_OFF_CNT_LO 16'h0004
`define LCES_OFF_CNT_HI 16'h0008
`define LCES_QUAL_INDEX 14'h0301
`define LCES_OFF_QUAL ({`LCES_QUAL_INDEX, 2'b00})

`define LCES_SEL_EVT_LSB 0
`define LCES_SEL_EVT_MSB 7
`define LCES_SEL_UMASK_LSB 8
`define LCES_SEL_UMASK_MSB 15
`define LCES_SEL_EN_BIT 16
`define LCES_SEL_RESET 32'h0000_0000
`define LCES_QUAL_RESET 4'h0
`define LCES_CNT_RESET 48'h0000_0000_0000

`define LCES_LLC_MISS_EVENT 8'h09
`define LCES_LLC_ALLOCATION_EVENT 8'h0A
`define LCES_LLC_VICTIM_EVENT 8'h0B
`define LCES_REMOTE_SNOOP_STATE_EVENT 8'h0C

`define LCES_UM_MISS_WRITE 8'h02
`define LCES_UM_MISS_PROBE 8'h04
`define LCES_UM_MISS_ANY 8'h03
`define LCES_UM_ALLOC_M 8'h01
`define LCES_UM_ALLOC_ANY 8'h0F
`define LCES_UM_VICTIM_ANY 8'h1F
`define LCES_UM_SNP_TO_S 8'h01
`define LCES_UM_SNP_TO_I 8'h02
`define LCES_UM_SNP_TO_S_QUAL 8'h04
`define LCES_UM_SNP_TO_I_QUAL 8'h08

`define LCES_QUAL_EXCLUSIVE 4'h2

`endif

// >>> rtl/lces_matcher.sv
// Event number and unit mask matcher giving the counter step of each cycle
`timescale 1ns/1ns
`include "lces_cfg.svh"
module lces_matcher
    import lces_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    lces_occ_if.match occ
);
    lces_incr_t incr_next;
    logic qual_hit;

    assign qual_hit = |(occ.snp_prev_state & occ.qual);

    always_comb begin
        incr_next = 3'h0;
        case (occ.evt)
            `LCES_LLC_MISS_EVENT: begin
                // Separate pulses may coincide, so the step is their sum
                incr_next = {2'b00, occ.umask[0] & occ.read_miss}
                    + {2'b00, occ.umask[1] & occ.write_miss}
                    + {2'b00, occ.umask[2] & occ.snoop_miss}; // [R1] [R2] [R3]
            end
            `LCES_LLC_ALLOCATION_EVENT: begin
                // Modified fills only come from a read-invalidate-own forward
                incr_next = {2'b00, occ.alloc_valid & |(occ.umask[3:0] &
                    {occ.alloc_state[3:1], occ.alloc_state[0] & occ.alloc_fwd_rio})}; // [R4] [R5] [R6]
            end
            `LCES_LLC_VICTIM_EVENT: begin
                incr_next = {2'b00, occ.victim_valid & |(occ.umask[4:0] & occ.victim_state)}; // [R7] [R8]
            end
            `LCES_REMOTE_SNOOP_STATE_EVENT: begin
                incr_next = {2'b00, occ.snp_valid & (
                    (occ.umask[0] & ~occ.snp_to_invalid) |
                    (occ.umask[1] & occ.snp_to_invalid) | // [R10]
                    (occ.umask[2] & ~occ.snp_to_invalid & qual_hit) | // [R11]
                    (occ.umask[3] & occ.snp_to_invalid & qual_hit))}; // [R12]
            end
            default: begin
                incr_next = 3'h0;
            end
        endcase
    end

    assign occ.incr = incr_next;

    a_miss_write: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (occ.evt == `LCES_LLC_MISS_EVENT && occ.umask == `LCES_UM_MISS_WRITE)
        |-> occ.incr == {2'b00, occ.write_miss})
        else $error("write miss step wrong");
    a_miss_probe: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (occ.evt == `LCES_LLC_MISS_EVENT && occ.umask == `LCES_UM_MISS_PROBE)
        |-> occ.incr == {2'b00, occ.snoop_miss})
        else $error("snoop miss step wrong");
    a_miss_any: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        (occ.evt == `LCES_LLC_MISS_EVENT && occ.umask == `LCES_UM_MISS_ANY && occ.read_miss && occ.write_miss)
        |-> occ.incr == 3'h2)
        else $error("read and write miss not summed");
    a_alloc_any: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        (occ.evt == `LCES_LLC_ALLOCATION_EVENT && occ.umask == `LCES_UM_ALLOC_ANY && occ.alloc_valid
        && |occ.alloc_state[3:1]) |-> occ.incr == 3'h1)
        else $error("allocation in any state missed");
    a_alloc_mod: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        (occ.evt == `LCES_LLC_ALLOCATION_EVENT && occ.umask == `LCES_UM_ALLOC_M && !occ.alloc_fwd_rio)
        |-> occ.incr == 3'h0)
        else $error("modified allocation counted without forward");
    a_victim_any: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (occ.evt == `LCES_LLC_VICTIM_EVENT && occ.umask == `LCES_UM_VICTIM_ANY)
        |-> occ.incr == {2'b00, occ.victim_valid && occ.victim_state != 5'h00})
        else $error("victim in any state step wrong");
    a_snoop_goto: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (occ.evt == `LCES_REMOTE_SNOOP_STATE_EVENT && occ.umask == `LCES_UM_SNP_TO_I)
        |-> occ.incr == {2'b00, occ.snp_valid && occ.snp_to_invalid})
        else $error("snoop to invalid step wrong");
    a_snoop_qual_s: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (occ.evt == `LCES_REMOTE_SNOOP_STATE_EVENT && occ.umask == `LCES_UM_SNP_TO_S_QUAL
        && (occ.snp_prev_state & occ.qual) == 4'h0) |-> occ.incr == 3'h0)
        else $error("unqualified snoop to shared counted");
    a_snoop_qual_i: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (occ.evt == `LCES_REMOTE_SNOOP_STATE_EVENT && occ.umask == `LCES_UM_SNP_TO_I_QUAL
        && occ.qual == `LCES_QUAL_EXCLUSIVE && occ.snp_valid && occ.snp_to_invalid)
        |-> occ.incr == {2'b00, occ.snp_prev_state[1]})
        else $error("exclusive snoop to invalid step wrong");
endmodule

// >>> rtl/lces_occ_if.sv
// Occurrences and selection passed from the top to the matcher
`timescale 1ns/1ns
interface lces_occ_if;
    import lces_pkg::*;
    logic read_miss;
    logic write_miss;
    logic snoop_miss;
    logic alloc_valid;
    lces_alloc_st_t alloc_state;
    logic alloc_fwd_rio;
    logic victim_valid;
    lces_victim_st_t victim_state;
    logic snp_valid;
    logic snp_to_invalid;
    lces_qual_t snp_prev_state;
    logic [7:0] evt;
    logic [7:0] umask;
    lces_qual_t qual;
    lces_incr_t incr;
    modport src (output read_miss, write_miss, snoop_miss, alloc_valid, alloc_state, alloc_fwd_rio,
        victim_valid, victim_state, snp_valid, snp_to_invalid, snp_prev_state, evt, umask, qual,
        input incr);
    modport match (input read_miss, write_miss, snoop_miss, alloc_valid, alloc_state, alloc_fwd_rio,
        victim_valid, victim_state, snp_valid, snp_to_invalid, snp_prev_state, evt, umask, qual,
        output incr);
endinterface

// >>> rtl/lces_pkg.sv
// Types shared by the event selector modules
package lces_pkg;
    // One-hot coherence state of an allocated line: bit0 M, bit1 E, bit2 S, bit3 F
    typedef logic [3:0] lces_alloc_st_t;
    // One-hot state of a victim: bit0 M, bit1 E, bit2 S, bit3 I, bit4 F
    typedef logic [4:0] lces_victim_st_t;
    // Previous-state mask of a snoop and of the qualifier: bit0 M, bit1 E, bit2 S, bit3 F
    typedef logic [3:0] lces_qual_t;
    typedef logic [2:0] lces_incr_t;
endpackage

// >>> rtl/lces_top.sv
// Coherence event selector with APB registers and one performance counter
//
// Function
// R1 - Write misses counted under miss event
// R2 - Count io_hub or remote snoop misses
// R3 - Count read plus write misses together
// R4 - Count allocations by fill state
// R5 - Count allocations in any state
// R6 - Modified fill counts only after forward
// R7 - Count victims by state at eviction
// R8 - Count victims in any state
// R9 - Write modified victim back to home
// R10 - Count remote snoops to shared, invalid
// R11 - Snoop to shared qualified by mask
// R12 - Snoop to invalid qualified by mask
// R13 - Step counter once per matching occurrence
`timescale 1ns/1ns
`include "lces_cfg.svh"
module lces_top
    import lces_pkg::*;
#(
    parameter int CNT_W = 48
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic llc_read_miss,
    input wire logic llc_write_miss,
    input wire logic llc_snoop_miss,
    input wire logic llc_alloc_valid,
    input wire lces_alloc_st_t llc_alloc_state,
    input wire logic llc_alloc_fwd_rio,
    input wire logic llc_victim_valid,
    input wire lces_victim_st_t llc_victim_state,
    input wire logic llc_victim_home_remote,
    input wire logic remote_snoop_valid,
    input wire logic remote_snoop_to_invalid,
    input wire lces_qual_t remote_snoop_prev_state,
    output logic wb_home_req,
    output logic wb_home_remote
);
    lces_occ_if occ ();

    logic [31:0] sel_reg;
    lces_qual_t qual_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [31:0] prdata_reg;
    logic wb_home_req_reg;
    logic wb_home_remote_reg;
    logic setup;
    logic access;
    logic wr_en;
    logic hit_sel;
    logic hit_cnt_lo;
    logic hit_cnt_hi;
    logic hit_qual;
    logic mapped;
    logic [63:0] cnt_wide;
    logic [31:0] rd_mux;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_val, input logic [31:0] new_val,
        input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign hit_sel = paddr == `LCES_OFF_SEL;
    assign hit_cnt_lo = paddr == `LCES_OFF_CNT_LO;
    assign hit_cnt_hi = paddr == `LCES_OFF_CNT_HI;
    assign hit_qual = paddr == `LCES_OFF_QUAL;
    assign mapped = hit_sel | hit_cnt_lo | hit_cnt_hi | hit_qual;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_en = access & pwrite & mapped;
    assign cnt_wide = {{(64 - CNT_W){1'b0}}, cnt_reg};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_sel) begin
            rd_mux = {15'h0000, sel_reg[`LCES_SEL_EN_BIT:0]};
        end else if (hit_cnt_lo) begin
            rd_mux = cnt_wide[31:0];
        end else if (hit_cnt_hi) begin
            rd_mux = cnt_wide[63:32];
        end else if (hit_qual) begin
            rd_mux = {28'h000_0000, qual_reg};
        end
    end

    // Read data latched in the setup cycle keeps prdata a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            prdata_reg <= rd_mux;
        end
    end
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= `LCES_SEL_RESET;
        end else if (wr_en & hit_sel) begin
            sel_reg <= apply_strb(sel_reg, pwdata, pstrb) & 32'h0001_FFFF;
        end
    end

    // Software owns the qualifier contents for the qualified snoop masks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qual_reg <= `LCES_QUAL_RESET;
        end else if (wr_en & hit_qual & pstrb[0]) begin
            qual_reg <= pwdata[3:0]; // [R11] [R12]
        end
    end

    assign occ.read_miss = llc_read_miss;
    assign occ.write_miss = llc_write_miss;
    assign occ.snoop_miss = llc_snoop_miss;
    assign occ.alloc_valid = llc_alloc_valid;
    assign occ.alloc_state = llc_alloc_state;
    assign occ.alloc_fwd_rio = llc_alloc_fwd_rio;
    assign occ.victim_valid = llc_victim_valid;
    assign occ.victim_state = llc_victim_state;
    assign occ.snp_valid = remote_snoop_valid;
    assign occ.snp_to_invalid = remote_snoop_to_invalid;
    assign occ.snp_prev_state = remote_snoop_prev_state;
    assign occ.evt = sel_reg[`LCES_SEL_EVT_MSB:`LCES_SEL_EVT_LSB];
    assign occ.umask = sel_reg[`LCES_SEL_UMASK_MSB:`LCES_SEL_UMASK_LSB];
    assign occ.qual = qual_reg;

    lces_matcher u_matcher (
        .pclk(pclk),
        .presetn(presetn),
        .occ(occ)
    );

    always_comb begin
        cnt_next = cnt_reg;
        if (sel_reg[`LCES_SEL_EN_BIT]) begin
            cnt_next = cnt_reg + CNT_W'(occ.incr); // [R13]
        end
    end

    // A software load wins over a count step in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= CNT_W'(`LCES_CNT_RESET);
        end else if (wr_en & hit_cnt_lo) begin
            cnt_reg <= CNT_W'({cnt_wide[63:32], apply_strb(cnt_wide[31:0], pwdata, pstrb)});
        end else if (wr_en & hit_cnt_hi) begin
            cnt_reg <= CNT_W'({apply_strb(cnt_wide[63:32], pwdata, pstrb), cnt_wide[31:0]});
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Dirty victims go home whether or not the counter watches them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_home_req_reg <= 1'b0;
            wb_home_remote_reg <= 1'b0;
        end else begin
            wb_home_req_reg <= llc_victim_valid & llc_victim_state[0]; // [R9]
            if (llc_victim_valid & llc_victim_state[0]) begin
                wb_home_remote_reg <= llc_victim_home_remote; // [R9]
            end
        end
    end
    assign wb_home_req = wb_home_req_reg;
    assign wb_home_remote = wb_home_remote_reg;

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (sel_reg[`LCES_SEL_EN_BIT] && !wr_en) |=> cnt_reg == $past(cnt_reg) + CNT_W'($past(occ.incr)))
        else $error("counter did not step by matched count");
    a_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (!sel_reg[`LCES_SEL_EN_BIT] && !wr_en) |=> $stable(cnt_reg))
        else $error("disabled counter moved");
    a_wb_home: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        (llc_victim_valid && llc_victim_state[0])
        |=> wb_home_req && wb_home_remote == $past(llc_victim_home_remote))
        else $error("modified victim not written home");
    a_wb_only_mod: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        !(llc_victim_valid && llc_victim_state[0]) |=> !wb_home_req)
        else $error("spurious writeback to home");
    a_alloc_state: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        (sel_reg[`LCES_SEL_EN_BIT] && occ.evt == `LCES_LLC_ALLOCATION_EVENT && occ.umask == 8'h02
        && llc_alloc_valid && llc_alloc_state == 4'h2 && !wr_en) |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("exclusive allocation not counted");
    a_victim_state: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        (sel_reg[`LCES_SEL_EN_BIT] && occ.evt == `LCES_LLC_VICTIM_EVENT && occ.umask == 8'h10
        && llc_victim_valid && llc_victim_state == 5'h10 && !wr_en) |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("forward victim not counted");
    a_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !mapped) |-> pslverr && pready)
        else $error("unmapped access not flagged");

    // Bus side checks: zero wait states are promised to every master
    a_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
        access
        |-> pready)
        else $error("pready low in access");

    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (access && mapped)
        |-> !pslverr)
        else $error("mapped access flagged");

    a_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !access
        |-> !pslverr)
        else $error("error outside access");

    a_rdata_load: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite)
        |=> prdata == $past(rd_mux))
        else $error("read data not loaded");

    a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(setup && !pwrite)
        |=> $stable(prdata))
        else $error("read data moved");

    a_sel_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |-> sel_reg[31:17] == 15'h0000)
        else $error("reserved select bits set");

    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (wr_en && hit_sel && pstrb == 4'hF)
        |=> sel_reg == ($past(pwdata) & 32'h0001_FFFF))
        else $error("select write lost");

    a_sel_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        !(wr_en && hit_sel)
        |=> $stable(sel_reg))
        else $error("select moved");

    a_qual_write: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (wr_en && hit_qual && pstrb[0])
        |=> qual_reg == $past(pwdata[3:0]))
        else $error("qualifier write lost");

    a_qual_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !(wr_en && hit_qual && pstrb[0])
        |=> $stable(qual_reg))
        else $error("qualifier moved");

    a_cnt_load_lo: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (wr_en && hit_cnt_lo && pstrb == 4'hF)
        |=> cnt_reg[31:0] == $past(pwdata))
        else $error("low count load lost");

    a_cnt_load_hi: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (wr_en && hit_cnt_hi && pstrb == 4'hF)
        |=> cnt_reg[CNT_W-1:32] == $past(pwdata[CNT_W-33:0]))
        else $error("high count load lost");

    a_unmapped_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !mapped)
        |=> $stable(sel_reg) && $stable(qual_reg))
        else $error("unmapped write landed");

    a_wb_remote_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        !(llc_victim_valid && llc_victim_state[0])
        |=> $stable(wb_home_remote))
        else $error("home select moved");

    a_other_event: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (occ.evt < 8'h09 || occ.evt > 8'h0C)
        |-> occ.incr == 3'h0)
        else $error("unknown event counted");

    a_step_range: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        occ.evt != `LCES_LLC_MISS_EVENT
        |-> occ.incr <= 3'h1)
        else $error("step above one");

    a_snoop_to_s: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (occ.evt == `LCES_REMOTE_SNOOP_STATE_EVENT && occ.umask == `LCES_UM_SNP_TO_S)
        |-> occ.incr == {2'b00, occ.snp_valid && !occ.snp_to_invalid})
        else $error("snoop to shared step wrong");

    a_miss_read: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (occ.evt == `LCES_LLC_MISS_EVENT && occ.umask == 8'h01)
        |-> occ.incr == {2'b00, occ.read_miss})
        else $error("read miss step wrong");
endmodule
